// ---- hdl/dual_interval_timer_pkg.sv ----
// Constants, register map and field layout of the dual interval timer.
// Assumes a 32-bit APB bus with byte addresses and one clock.
package dual_interval_timer_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          CNT_W           = 16;
    localparam int          EV_PER_TIMER    = 3;
    // Per-timer offsets; the second timer sits at SECOND_TIMER_BASE
    localparam logic [5:0]  CONTROL_OFS     = 6'h00;
    localparam logic [5:0]  COUNTER_OFS     = 6'h04;
    localparam logic [5:0]  VECTOR_OFS      = 6'h08;
    localparam logic [5:0]  CHCTL0_OFS      = 6'h0c;
    localparam logic [5:0]  CHCTL1_OFS      = 6'h10;
    localparam logic [5:0]  CMP0_OFS        = 6'h14;
    localparam logic [5:0]  CMP1_OFS        = 6'h18;
    localparam logic [7:0]  SECOND_TIMER_BASE = 8'h40;
    localparam logic [7:0]  IRQ_STATUS_OFS  = 8'h80;
    localparam logic [7:0]  IRQ_MASK_OFS    = 8'h84;
    // Control register fields
    localparam int          CTL_OVF_BIT     = 0;
    localparam int          CTL_CLEAR_BIT   = 2;
    localparam int          CTL_MODE_LSB    = 4;
    localparam int          CTL_DIV_LSB     = 6;
    localparam int          CTL_SRC_LSB     = 8;
    // Channel control fields
    localparam int          CCTL_FLAG_BIT   = 0;
    localparam int          CCTL_CAPTURE_BIT = 8;
    localparam logic [15:0] CNT_MAX         = 16'hffff;
    localparam logic [15:0] VEC_NONE        = 16'h0000;
    localparam logic [15:0] VEC_CH0         = 16'h0002;
    localparam logic [15:0] VEC_CH1         = 16'h0004;
    localparam logic [15:0] VEC_OVF         = 16'h000a;
    localparam logic [3:0]  FULL_WORD_STRB  = 4'hf;

    typedef enum logic [1:0] {
        MODE_STOP = 2'b00,
        MODE_UP   = 2'b01,
        MODE_CONT = 2'b10,
        MODE_ALT  = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        SRC_EXT = 2'b00,
        SRC_AUX = 2'b01,
        SRC_SUB = 2'b10,
        SRC_INV = 2'b11
    } src_t;
endpackage : dual_interval_timer_pkg

// ---- hdl/dual_interval_timer.sv ----
// Two 16-bit interval timers with two capture/compare channels each,
// an APB register slave and one masked level interrupt.
// Assumes count sources and capture pins are synchronous to clk.
`timescale 1ns/10ps
module dual_interval_timer
    import dual_interval_timer_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              soft_system_reset,
    input  wire logic              first_external_count_clock,
    input  wire logic              second_external_count_clock,
    input  wire logic [1:0]        inverted_input_clock,
    input  wire logic              aux_clock,
    input  wire logic              subsystem_clock,
    input  wire logic [3:0]        capture_in,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq
);

    typedef struct packed {
        logic [1:0][CNT_W-1:0]      cnt;
        logic [1:0][1:0]            mode;
        logic [1:0][1:0]            div;
        logic [1:0][1:0]            src;
        logic [1:0]                 ovf;
        logic [1:0][1:0][CNT_W-1:0] cmp;
        logic [1:0][1:0]            capm;
        logic [1:0][1:0]            chf;
        logic [1:0][1:0]            capprev;
        logic [1:0]                 srcprev;
        logic [1:0][2:0]            divcnt;
        logic [5:0]                 stat;
        logic [5:0]                 mask;
        logic [31:0]                rdata;
    } state_t;

    state_t          r_reg;
    state_t          r_next;
    logic            acc;
    logic            wr;
    logic [1:0]      hit;
    logic [1:0]      clr_wr;
    logic [1:0]      ctl_full;
    logic [1:0]      src_now;
    logic [1:0]      tick;
    logic [1:0]      ext_pin;
    logic [5:0]      off;

    // Level of the selected count source; source 11 counts the inverted pin
    function automatic logic src_level(input logic [1:0] sel, input logic ext,
                                       input logic inv);
        case (sel)
            SRC_EXT: src_level = ext;
            SRC_AUX: src_level = aux_clock;
            SRC_SUB: src_level = subsystem_clock;
            default: src_level = ~inv;
        endcase
    endfunction : src_level

    // Source edges counted by the divider before one counter increment
    function automatic logic [2:0] div_limit(input logic [1:0] d);
        div_limit = 3'((4'h1 << d) - 4'h1);
    endfunction : div_limit

    // Highest pending source, channel zero first
    function automatic logic [15:0] vec_code(input logic ovf, input logic [1:0] chf);
        if (chf[0])
            vec_code = VEC_CH0;
        else if (chf[1])
            vec_code = VEC_CH1;
        else if (ovf)
            vec_code = VEC_OVF;
        else
            vec_code = VEC_NONE;
    endfunction : vec_code

    // Only mapped, word-aligned offsets are accepted
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        if (a[7])
            addr_ok = (a == IRQ_STATUS_OFS) || (a == IRQ_MASK_OFS);
        else
            addr_ok = (a[1:0] == 2'b00) && (a[5:0] <= CMP1_OFS);
    endfunction : addr_ok

    assign pready  = 1'b1;
    assign pslverr = acc && !addr_ok(paddr);
    assign prdata  = r_reg.rdata;
    assign irq     = |(r_reg.stat & r_reg.mask);
    assign ext_pin = {second_external_count_clock, first_external_count_clock};

    // Bus decode and count-edge detection per timer
    always_comb begin : decode
        acc = psel && penable;
        wr  = acc && pwrite && addr_ok(paddr);
        off = paddr[5:0];
        for (int t = 0; t < 2; t++) begin
            hit[t]      = !paddr[7] && (paddr[6] == t[0]);
            clr_wr[t]   = wr && hit[t] && off == CONTROL_OFS && pstrb[0]
                          && pwdata[CTL_CLEAR_BIT];
            ctl_full[t] = wr && hit[t] && off == CONTROL_OFS && pstrb == FULL_WORD_STRB;
            src_now[t]  = src_level(r_reg.src[t], ext_pin[t], inverted_input_clock[t]);
            tick[t]     = src_now[t] && !r_reg.srcprev[t]
                          && r_reg.mode[t] != MODE_STOP
                          && r_reg.divcnt[t] == div_limit(r_reg.div[t])
                          && !clr_wr[t] && !soft_system_reset;
        end
    end

    always_comb begin : next_state
        logic [1:0]       ev_ovf;
        logic [1:0][1:0]  ev_ch;
        logic [CNT_W-1:0] nxt;
        logic [15:0]      vec;
        logic [1:0]       cap;
        ev_ovf = '0;
        ev_ch  = '0;
        nxt    = '0;
        vec    = '0;
        cap    = '0;
        r_next = r_reg;
        for (int t = 0; t < 2; t++) begin
            r_next.srcprev[t] = src_now[t];
            // Soft reset restarts counting but keeps control and flags
            if (clr_wr[t] || soft_system_reset) begin
                r_next.cnt[t]    = '0;
                r_next.divcnt[t] = '0;
            end else if (src_now[t] && !r_reg.srcprev[t] && r_reg.mode[t] != MODE_STOP) begin
                if (tick[t])
                    r_next.divcnt[t] = '0;
                else
                    r_next.divcnt[t] = 3'(r_reg.divcnt[t] + 3'h1);
            end
            if (tick[t]) begin
                if ((r_reg.mode[t] == MODE_UP && r_reg.cnt[t] >= r_reg.cmp[t][0])
                    || r_reg.cnt[t] == CNT_MAX)
                    nxt = '0;
                else
                    nxt = 16'(r_reg.cnt[t] + 16'h1);
                r_next.cnt[t] = nxt;
                // Overflow only on the real rollover transition
                if (r_reg.mode[t] == MODE_UP)
                    ev_ovf[t] = r_reg.cnt[t] == r_reg.cmp[t][0];
                else
                    ev_ovf[t] = r_reg.cnt[t] == CNT_MAX;
                // Compare uses the register value live at the count edge
                for (int c = 0; c < 2; c++)
                    if (!r_reg.capm[t][c] && nxt == r_reg.cmp[t][c])
                        ev_ch[t][c] = 1'b1;
            end
            // A rising capture pin copies the counter in capture mode
            for (int c = 0; c < 2; c++) begin
                cap = capture_in[2*t +: 2];
                r_next.capprev[t][c] = cap[c];
                if (r_reg.capm[t][c] && cap[c] && !r_reg.capprev[t][c]) begin
                    r_next.cmp[t][c] = r_reg.cnt[t];
                    ev_ch[t][c]      = 1'b1;
                end
            end
            // Register writes from the bus
            if (wr && hit[t]) begin
                case (off)
                    CONTROL_OFS: begin
                        if (pstrb[0] && !pwdata[CTL_OVF_BIT])
                            r_next.ovf[t] = 1'b0;
                        if (pstrb[0]) begin
                            r_next.mode[t] = pwdata[CTL_MODE_LSB +: 2];
                            r_next.div[t]  = pwdata[CTL_DIV_LSB +: 2];
                        end
                        if (pstrb[1])
                            r_next.src[t] = pwdata[CTL_SRC_LSB +: 2];
                    end
                    COUNTER_OFS: begin
                        if (pstrb[1:0] == 2'b11)
                            r_next.cnt[t] = pwdata[15:0];
                    end
                    CHCTL0_OFS, CHCTL1_OFS: begin
                        if (pstrb[0] && !pwdata[CCTL_FLAG_BIT])
                            r_next.chf[t][off == CHCTL1_OFS] = 1'b0;
                        if (pstrb[1])
                            r_next.capm[t][off == CHCTL1_OFS] = pwdata[CCTL_CAPTURE_BIT];
                    end
                    CMP0_OFS, CMP1_OFS: begin
                        // Compare values accept bus-speed updates at any time
                        if (pstrb[1:0] == 2'b11)
                            r_next.cmp[t][off == CMP1_OFS] = pwdata[15:0];
                    end
                    default: ;
                endcase
            end
            if (ctl_full[t]) begin
                r_next.ovf[t] = 1'b0;
                r_next.chf[t] = '0;
            end
            // Reading the vector acknowledges the highest pending source
            if (acc && !pwrite && hit[t] && off == VECTOR_OFS) begin
                vec = vec_code(r_reg.ovf[t], r_reg.chf[t]);
                if (vec == VEC_CH0)
                    r_next.chf[t][0] = 1'b0;
                else if (vec == VEC_CH1)
                    r_next.chf[t][1] = 1'b0;
                else if (vec == VEC_OVF)
                    r_next.ovf[t] = 1'b0;
            end
        end
        if (wr && paddr == IRQ_STATUS_OFS)
            r_next.stat = r_reg.stat & ~pwdata[5:0];
        if (wr && paddr == IRQ_MASK_OFS)
            r_next.mask = pwdata[5:0];
        // Hardware events win over any clear in the same cycle
        for (int t = 0; t < 2; t++) begin
            r_next.ovf[t] = r_next.ovf[t] | ev_ovf[t];
            r_next.chf[t] = r_next.chf[t] | ev_ch[t];
            r_next.stat[EV_PER_TIMER*t +: EV_PER_TIMER] =
                r_next.stat[EV_PER_TIMER*t +: EV_PER_TIMER] | {ev_ch[t], ev_ovf[t]};
        end
        // Read data is captured in the setup phase
        if (psel && !penable && !pwrite) begin
            r_next.rdata = '0;
            if (paddr == IRQ_STATUS_OFS)
                r_next.rdata = {26'h0, r_reg.stat};
            else if (paddr == IRQ_MASK_OFS)
                r_next.rdata = {26'h0, r_reg.mask};
            else if (!paddr[7] && addr_ok(paddr)) begin
                case (off)
                    CONTROL_OFS: r_next.rdata = {22'h0, r_reg.src[paddr[6]],
                                                 r_reg.div[paddr[6]], r_reg.mode[paddr[6]],
                                                 3'h0, r_reg.ovf[paddr[6]]};
                    COUNTER_OFS: r_next.rdata = {16'h0, r_reg.cnt[paddr[6]]};
                    VECTOR_OFS:  r_next.rdata = {16'h0, vec_code(r_reg.ovf[paddr[6]],
                                                                 r_reg.chf[paddr[6]])};
                    CHCTL0_OFS:  r_next.rdata = {23'h0, r_reg.capm[paddr[6]][0], 7'h0,
                                                 r_reg.chf[paddr[6]][0]};
                    CHCTL1_OFS:  r_next.rdata = {23'h0, r_reg.capm[paddr[6]][1], 7'h0,
                                                 r_reg.chf[paddr[6]][1]};
                    CMP0_OFS:    r_next.rdata = {16'h0, r_reg.cmp[paddr[6]][0]};
                    CMP1_OFS:    r_next.rdata = {16'h0, r_reg.cmp[paddr[6]][1]};
                    default:     r_next.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    chk_up_overflow_first: assert property (@(posedge clk) disable iff (reset)
        tick[0] && r_reg.mode[0] == MODE_UP && !r_reg.ovf[0] |=>
            r_reg.ovf[0] == ($past(r_reg.cnt[0]) == $past(r_reg.cmp[0][0])))
        else $error("first timer overflow flag wrong at up-mode count");

    chk_up_overflow_second: assert property (@(posedge clk) disable iff (reset)
        !r_reg.ovf[1] ##1 r_reg.ovf[1] |->
            $past(tick[1]) && r_reg.cnt[1] == 16'h0000)
        else $error("second timer overflow without rollover to zero");

    chk_clear_zeroes: assert property (@(posedge clk) disable iff (reset)
        clr_wr[0] |=> r_reg.cnt[0] == 16'h0000 && r_reg.divcnt[0] == 3'h0)
        else $error("clear did not zero counter and divider");

    chk_clear_no_flag: assert property (@(posedge clk) disable iff (reset)
        tick[1] && r_reg.mode[1] == MODE_UP && r_reg.cnt[1] == 16'h0000
            && r_reg.cmp[1][0] != 16'h0000 && !r_reg.ovf[1] |=> !r_reg.ovf[1])
        else $error("overflow set on first count after clear");

    chk_compare_hit: assert property (@(posedge clk) disable iff (reset)
        $past(tick[0]) && !$past(r_reg.capm[0][0])
            && r_reg.cnt[0] == $past(r_reg.cmp[0][0]) |-> r_reg.chf[0][0])
        else $error("compare event lost at count edge");

    chk_divider_rate: assert property (@(posedge clk) disable iff (reset)
        tick[1] && r_reg.div[1] != 2'b00 |-> r_reg.divcnt[1] != 3'h0)
        else $error("count taken before divider elapsed");

    chk_source_edge: assert property (@(posedge clk) disable iff (reset)
        tick[1] |-> src_now[1] && !r_reg.srcprev[1] && !$past(src_now[1]))
        else $error("count without rising source edge");

    chk_soft_keeps: assert property (@(posedge clk) disable iff (reset)
        soft_system_reset && !wr && !tick[0] |=>
            $stable(r_reg.mode[0]) && $stable(r_reg.div[0]) && $stable(r_reg.src[0])
            && r_reg.ovf[0] == $past(r_reg.ovf[0]))
        else $error("soft reset altered control or vector");

    chk_full_clears: assert property (@(posedge clk) disable iff (reset)
        ctl_full[1] && !tick[1] && capture_in[3:2] == 2'b00 |=>
            vec_code(r_reg.ovf[1], r_reg.chf[1]) == VEC_NONE)
        else $error("full control write left vector pending");

    chk_up_wraps: assert property (@(posedge clk) disable iff (reset)
        tick[0] && r_reg.mode[0] == MODE_UP && r_reg.cnt[0] >= r_reg.cmp[0][0] |=>
            r_reg.cnt[0] == 16'h0000)
        else $error("up-mode counter did not return to zero at period");

    chk_soft_zeroes: assert property (@(posedge clk) disable iff (reset)
        soft_system_reset && !wr |=>
            r_reg.cnt[1] == 16'h0000 && r_reg.divcnt[1] == 3'h0)
        else $error("soft reset did not zero second counter and divider");

    chk_soft_keeps_second: assert property (@(posedge clk) disable iff (reset)
        soft_system_reset && !acc && capture_in[3:2] == 2'b00 |=>
            $stable(r_reg.mode[1]) && $stable(r_reg.div[1]) && $stable(r_reg.src[1])
            && $stable(r_reg.ovf[1]) && $stable(r_reg.chf[1]))
        else $error("soft reset altered second control or vector");

    chk_status_sticky: assert property (@(posedge clk) disable iff (reset)
        r_reg.stat[0] && !(wr && paddr == IRQ_STATUS_OFS && pwdata[0]) |=> r_reg.stat[0])
        else $error("status bit dropped without a write of one");

    chk_timers_independent: assert property (@(posedge clk) disable iff (reset)
        tick[0] && !tick[1] && !clr_wr[1] && !soft_system_reset && !(wr && hit[1]) |=>
            $stable(r_reg.cnt[1]))
        else $error("second counter moved on a first timer event");

    chk_divider_count: assert property (@(posedge clk) disable iff (reset)
        tick[1] && r_reg.div[1] == 2'b10 |-> r_reg.divcnt[1] == 3'h3)
        else $error("divide-by-four count taken on wrong source edge");

endmodule : dual_interval_timer

// ---- test/testbench.sv ----
// Self-checking bench of the dual interval timer over APB.
// Assumes a zero-wait APB slave and count sources sampled by clk.
`timescale 1ns/10ps
module testbench
    import dual_interval_timer_pkg::*;
;
    logic              clk;
    logic              reset;
    logic              soft_system_reset;
    logic              first_external_count_clock;
    logic              second_external_count_clock;
    logic [1:0]        inverted_input_clock;
    logic              aux_clock;
    logic              subsystem_clock;
    logic [3:0]        capture_in;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    logic [31:0]       rd;
    logic              err;
    int                bad_count;
    int                cmp_count;
    int                p;
    int                k;

    dual_interval_timer dual_interval_timer_inst (.clk(clk), .reset(reset),
        .soft_system_reset(soft_system_reset),
        .first_external_count_clock(first_external_count_clock),
        .second_external_count_clock(second_external_count_clock),
        .inverted_input_clock(inverted_input_clock), .aux_clock(aux_clock),
        .subsystem_clock(subsystem_clock), .capture_in(capture_in), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

    always #5 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk("pready wait", 32'h0, 32'(n));
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [7:0] ad(input int t, input logic [5:0] o);
        return (t != 0 ? SECOND_TIMER_BASE : 8'h00) + {2'b00, o};
    endfunction : ad

    function automatic logic [31:0] ctl(input int m, input int dv, input int s, input int c);
        return (32'(m) << CTL_MODE_LSB) | (32'(dv) << CTL_DIV_LSB)
             | (32'(s) << CTL_SRC_LSB) | (32'(c) << CTL_CLEAR_BIT);
    endfunction : ctl

    // Counter value after n ticks in up mode with period value pv
    function automatic logic [31:0] up_cnt(input int pv, input int n);
        return 32'(n % (pv + 1));
    endfunction : up_cnt

    task automatic wr(input int t, input logic [5:0] o, input logic [31:0] d);
        apb(1'b1, ad(t, o), d, FULL_WORD_STRB);
    endtask : wr

    task automatic rdr(input int t, input logic [5:0] o);
        apb(1'b0, ad(t, o), 32'h0, 4'h0);
    endtask : rdr

    // Inverted source idles high so a falling pin edge is a rising count edge
    task automatic drive(input int t, input int s, input logic v);
        case (s)
            0: if (t != 0) second_external_count_clock <= v; else first_external_count_clock <= v;
            1: aux_clock <= v;
            2: subsystem_clock <= v;
            default: inverted_input_clock[t] <= ~v;
        endcase
    endtask : drive

    task automatic tick(input int t, input int s, input int n);
        repeat (n) begin
            @(posedge clk);
            drive(t, s, 1'b1);
            repeat (2) @(posedge clk);
            drive(t, s, 1'b0);
            @(posedge clk);
        end
    endtask : tick

    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("[ERR] watchdog expected finish seen timeout");
        stop_test();
    end

    initial begin
        clk = 0; reset = 1; soft_system_reset = 0; capture_in = 4'h0;
        first_external_count_clock = 0; second_external_count_clock = 0;
        inverted_input_clock = 2'b11; aux_clock = 0; subsystem_clock = 0;
        psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0;
        bad_count = 0; cmp_count = 0;
        void'($urandom(33));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rdr(0, CONTROL_OFS); chk("control reset", 32'h0, rd);
        rdr(1, COUNTER_OFS); chk("counter reset", 32'h0, rd);
        apb(1'b0, 8'hfc, 32'h0, 4'h0); chk("unmapped error", 32'h1, {31'h0, err});
        k = $urandom % 65536;
        wr(1, COUNTER_OFS, k);
        rdr(1, COUNTER_OFS);
        chk("counter write", k, rd);
        $display("test reset done");
        for (int t = 0; t < 2; t++) begin
            p = 2 + $urandom % 5;
            wr(t, CMP0_OFS, p);
            wr(t, CONTROL_OFS, ctl(MODE_UP, 0, SRC_AUX, 1));
            tick(t, SRC_AUX, p);
            rdr(t, COUNTER_OFS); chk("up count", up_cnt(p, p), rd);
            rdr(t, CONTROL_OFS); chk("early overflow", 32'h0, {31'h0, rd[0]});
            tick(t, SRC_AUX, 1);
            rdr(t, COUNTER_OFS); chk("rollover", up_cnt(p, p + 1), rd);
            rdr(t, CONTROL_OFS); chk("overflow flag", 32'h1, {31'h0, rd[0]});
            apb(1'b1, IRQ_MASK_OFS, 32'h1 << (t * 3), 4'hf);
            @(negedge clk); chk("irq raised", 32'h1, {31'h0, irq});
            apb(1'b1, IRQ_STATUS_OFS, 32'h3f, 4'hf);
            @(negedge clk); chk("irq cleared", 32'h0, {31'h0, irq});
            wr(t, CONTROL_OFS, ctl(MODE_UP, 0, SRC_AUX, 0));
            rdr(t, VECTOR_OFS); chk("vector init", {16'h0, VEC_NONE}, rd);
        end
        $display("test up mode done");
        tick(1, SRC_AUX, p);
        wr(1, CONTROL_OFS, ctl(MODE_STOP, 0, SRC_AUX, 0));
        wr(1, CONTROL_OFS, ctl(MODE_UP, 0, SRC_AUX, 1));
        rdr(1, COUNTER_OFS); chk("clear", 32'h0, rd);
        tick(1, SRC_AUX, 1);
        rdr(1, COUNTER_OFS); chk("restart count", 32'h1, rd);
        rdr(1, CONTROL_OFS); chk("no false overflow", 32'h0, {31'h0, rd[0]});
        $display("test clear done");
        k = 3 + $urandom % 4;
        wr(0, CMP1_OFS, k);
        wr(0, CONTROL_OFS, ctl(MODE_CONT, 0, SRC_SUB, 1));
        tick(0, SRC_SUB, k);
        rdr(0, CHCTL1_OFS); chk("compare hit", 32'h1, {31'h0, rd[0]});
        for (int j = 0; j < 2; j++) begin
            if (j == 1) wr(0, CHCTL1_OFS, 32'h1 << CCTL_CAPTURE_BIT);
            wr(0, CMP1_OFS, k + 1 + j);
            wr(0, CHCTL1_OFS, 32'h0);
            tick(0, SRC_SUB, 1);
            rdr(0, CHCTL1_OFS); chk("raised compare hit", 32'h1, {31'h0, rd[0]});
        end
        wr(0, CHCTL0_OFS, 32'h1 << CCTL_CAPTURE_BIT);
        @(posedge clk);
        capture_in[0] <= 1'b1;
        @(posedge clk);
        capture_in[0] <= 1'b0;
        rdr(0, CMP0_OFS);
        chk("capture value", k + 2, rd);
        rdr(0, VECTOR_OFS);
        chk("vector channel zero", {16'h0, VEC_CH0}, rd);
        rdr(0, VECTOR_OFS);
        chk("vector channel one", {16'h0, VEC_CH1}, rd);
        $display("test compare done");
        wr(1, CONTROL_OFS, ctl(MODE_CONT, 2, SRC_EXT, 1));
        tick(1, SRC_EXT, 3);
        rdr(1, COUNTER_OFS); chk("first divided", 32'h0, rd);
        tick(1, SRC_EXT, 5);
        rdr(1, COUNTER_OFS); chk("divided rate", 32'h2, rd);
        tick(1, SRC_EXT, 2);
        @(posedge clk); soft_system_reset <= 1'b1;
        @(posedge clk); soft_system_reset <= 1'b0;
        rdr(1, COUNTER_OFS); chk("soft reset count", 32'h0, rd);
        rdr(1, CONTROL_OFS);
        chk("soft reset control", ctl(MODE_CONT, 2, SRC_EXT, 0), rd & 32'h3f0);
        tick(1, SRC_EXT, 3);
        rdr(1, COUNTER_OFS); chk("divider restart", 32'h0, rd);
        $display("test divider done");
        for (int s = 0; s < 4; s++) begin
            for (int t = 0; t < 2; t++) begin
                k = 1 + $urandom % 3;
                wr(t, CONTROL_OFS, ctl(MODE_CONT, 0, s, 1));
                tick(t, s, k);
                tick(t, (s + 1) % 4, 1);
                rdr(t, COUNTER_OFS); chk("source count", 32'(k), rd);
            end
        end
        $display("test sources done");
        stop_test();
    end
endmodule : testbench
